// ---- core/sclksw_top.sv ----
// system clock source switch, divider and peripheral clock selection
`timescale 1ns/1ps
module sclksw_top
  import sclksw_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire sclksw_req_s req,
  input wire logic [OSC_N-1:0] osc_raw,
  input wire logic stop_mode,
  input wire logic fast_recovery_enable,
  output logic [7:0] rdata,
  output logic sys_clk,
  output logic pclk
);

  // ----------------------------------------
  // state and combinational helpers
  // ----------------------------------------
  sclksw_state_s q; // all registered state
  sclksw_state_s d; // next state
  logic [7:0] srcv; // synced system sources, padded so any code indexes safely
  logic [3:0] pv; // synced peripheral sources, code 3 reads low
  logic [3:0] pvp; // the same sources one cycle earlier, for fall detection
  logic [2:0] sel; // requested system source
  logic sel_ok; // requested code names a real source
  logic [1:0] psel; // requested peripheral source
  logic pbit; // current peripheral source level
  logic allow; // peripheral clock may run now
  logic [HCNT_W-1:0] lim; // edges per output half period, minus one
  logic wr0; // write to ctl0
  logic unl; // registers unlocked

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // oscillators are sampled on clk, so every switch decision works on clean levels;
  // the trade is that sources must run well below half the clk rate
  always_comb begin
    d = q;
    d.sync1 = osc_raw;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2; // edge history only, never a sync stage
    srcv = {3'h0, q.sync2[3], q.sync2[2], q.sync2[1], q.sync2[0], q.pclk};
    pv = {1'b0, q.sync2[6], q.sync2[5], q.sync2[4]};
    pvp = {1'b0, q.sync3[6], q.sync3[5], q.sync3[4]};
    sel = q.ctl0[SEL_LSB +: 3];
    sel_ok = (sel <= SRC_WDT);
    psel = q.ctl1[PSEL_LSB +: 2];
    pbit = pv[q.pcur];
    unl = q.ctl0[UNLOCKED_BIT];
    wr0 = req.wr && (req.addr == CTL0_ADDR);

    // unlock sequence and ctl0 writes
    if (wr0) begin
      if (unl) begin
        d.ctl0 = req.wdata; // unlock values simply load here
      end else if (q.stage && (req.wdata == UNLOCK_2)) begin
        d.ctl0[UNLOCKED_BIT] = 1'b1; // second value completes the unlock
        d.stage = 1'b0;
      end else begin
        d.stage = (req.wdata == UNLOCK_1); // other values restart the sequence
      end
    end
    // ctl1 only changes while unlocked
    if (req.wr && (req.addr == CTL1_ADDR) && unl) begin
      d.ctl1 = req.wdata;
    end

    // read data stands for one cycle only
    d.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        CTL0_ADDR: d.rdata = q.ctl0;
        CTL1_ADDR: d.rdata = q.ctl1;
        STAT_ADDR: d.rdata = {1'b0, q.pon, q.sw != SW_IDLE, q.pcur, q.cur};
        default: d.rdata = 8'h00; // unmapped reads as zero
      endcase
    end

    // system source switch: drain old, see a high of the new, open on its fall
    unique case (q.sw)
      SW_IDLE: begin
        if (sel_ok && (sel != q.cur)) begin
          d.sw = SW_DRAIN;
        end
      end
      SW_DRAIN: begin
        // gate the old source only in its low phase
        if (!srcv[q.cur]) begin
          d.on = 1'b0;
          d.cur = sel_ok ? sel : q.cur;
          d.sw = SW_ARM;
        end
      end
      SW_ARM: begin
        // a low level alone may be its last cycle, which would cut the low phase short
        if (srcv[q.cur]) begin
          d.sw = SW_OPEN;
        end
      end
      SW_OPEN: begin
        // open the new source at the start of its low phase
        if (!srcv[q.cur]) begin
          d.on = 1'b1;
          d.sw = SW_IDLE;
        end
      end
    endcase
    d.mux = q.on & srcv[q.cur];

    // divider counts half periods of the muxed source
    lim = HCNT_W'((9'h001 << q.div_act) - 9'h001);
    if (d.mux != q.mux) begin
      if (q.hcnt == lim) begin
        d.hcnt = '0;
        d.sclk = ~q.sclk;
        // new ratio only at a period start, so no half is cut
        if (!q.sclk) begin
          d.div_act = q.ctl1[DIV_LSB +: DIV_W];
        end
      end else begin
        d.hcnt = q.hcnt + 1'b1;
      end
    end

    // peripheral clock: select and stop gating move in low phases only
    allow = !stop_mode ||
      (q.ctl1[KEEP_BIT] && ((q.pcur != PCLK_IPO) || fast_recovery_enable));
    if (!pbit) begin
      // the new source must have just fallen, so the pclk low phase is never cut short
      if ((psel <= PCLK_EXT2) && (psel != q.pcur) && pvp[psel] && !pv[psel]) begin
        d.pcur = psel;
      end
      d.pon = allow;
    end
    d.pclk = q.pon & pbit; // dco reference and peripheral clock
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign sys_clk = q.sclk;
  assign pclk = q.pclk;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  lock_ignore_a: assert property (
    (req.wr && (req.addr == CTL1_ADDR) && !q.ctl0[UNLOCKED_BIT]) |=> $stable(q.ctl1))
    else $error("ctl1 changed while locked");
  unlock_seq_a: assert property (
    (wr0 && !q.ctl0[UNLOCKED_BIT] && q.stage && (req.wdata == UNLOCK_2))
      |=> q.ctl0[UNLOCKED_BIT] && $stable(q.ctl0[6:0]))
    else $error("unlock sequence did not unlock");
  relock_a: assert property (
    (wr0 && q.ctl0[UNLOCKED_BIT] && !req.wdata[UNLOCKED_BIT]) |=> !q.ctl0[UNLOCKED_BIT])
    else $error("clearing flag did not relock");
  load_unlocked_a: assert property (
    (wr0 && q.ctl0[UNLOCKED_BIT]) |=> (q.ctl0 == $past(req.wdata)))
    else $error("unlocked write not loaded");
  drain_hold_a: assert property (
    ((q.sw == SW_DRAIN) && srcv[q.cur]) |=> q.on && (q.sw == SW_DRAIN))
    else $error("old source gated in high phase");
  arm_hold_a: assert property (
    ((q.sw == SW_ARM) && srcv[q.cur]) |=> !q.on && !q.mux)
    else $error("new source opened in high phase");
  open_hold_a: assert property (
    ((q.sw == SW_OPEN) && srcv[q.cur]) |=> !q.on && (q.sw == SW_OPEN))
    else $error("new source opened before its fall");
  pclk_switch_a: assert property (
    !$stable(q.pcur) |-> !q.pclk && !pbit)
    else $error("pclk source moved outside a low phase");
  switch_delay_a: assert property (
    ((q.sw == SW_IDLE) && sel_ok && (sel != q.cur)) |=> (q.sw == SW_DRAIN) ##1 1'b1)
    else $error("switch did not start");
  div_change_a: assert property (
    !$stable(q.div_act) |-> $rose(q.sclk))
    else $error("divider changed mid period");
  wdt_pass_a: assert property (
    ((q.sw == SW_IDLE) && q.on && (q.cur == SRC_WDT)) |=> (q.mux == $past(q.sync2[3])))
    else $error("watchdog osc not passed");
  stop_gate_a: assert property (
    (stop_mode && !q.ctl1[KEEP_BIT] && !pbit) ##1 stop_mode [*2] |-> !q.pclk)
    else $error("pclk ran in stop without keep");
  pclk_follow_a: assert property (
    (q.pon && (q.pcur == PCLK_LOW_FREQ_CRYSTAL_OSC)) |=> (q.pclk == $past(q.sync2[5])))
    else $error("pclk not following crystal");

endmodule

// ---- core/sclksw_pkg.sv ----
// constants, types and reset state of the system clock source switch
package sclksw_pkg;

  // ----------------------------------------
  // register map and field layout
  // ----------------------------------------
  localparam int ADDR_W = 2;                     // register port address width
  localparam logic [1:0] CTL0_ADDR = 2'h0;       // primary_clock_control_reg
  localparam logic [1:0] CTL1_ADDR = 2'h1;       // divider, peripheral clock, stop keep
  localparam logic [1:0] STAT_ADDR = 2'h2;       // live switch state, read only
  localparam logic [7:0] CTL0_RST = 8'h00;       // locked, system clock from pclk
  localparam logic [7:0] CTL1_RST = 8'h00;       // divide by 1, pclk from precision osc
  localparam logic [7:0] UNLOCK_1 = 8'hE7;       // first unlock value
  localparam logic [7:0] UNLOCK_2 = 8'h18;       // second unlock value
  localparam int UNLOCKED_BIT = 7;               // clock_regs_unlocked_flag in ctl0
  localparam int SEL_LSB = 0;                    // system_clock_source_select, 3 bits
  localparam int DIV_LSB = 0;                    // divider exponent in ctl1, 3 bits
  localparam int PSEL_LSB = 3;                   // peripheral clock select in ctl1, 2 bits
  localparam int KEEP_BIT = 5;                   // peripheral_clock_stop_keep in ctl1
  localparam int DIV_W = 3;                      // divide by 2**n, n up to 7
  localparam int HCNT_W = 8;                     // half-period edge counter width

  // ----------------------------------------
  // source codes and raw oscillator inputs
  // ----------------------------------------
  localparam logic [2:0] SRC_PCLK = 3'h0;
  localparam logic [2:0] SRC_DCO = 3'h1;
  localparam logic [2:0] SRC_HF = 3'h2;
  localparam logic [2:0] SRC_PLL = 3'h3;
  localparam logic [2:0] SRC_WDT = 3'h4;         // watchdog_osc, highest legal code
  localparam logic [1:0] PCLK_IPO = 2'h0;        // internal_precision_osc
  localparam logic [1:0] PCLK_LOW_FREQ_CRYSTAL_OSC = 2'h1;       // low_freq_crystal_osc
  localparam logic [1:0] PCLK_EXT2 = 2'h2;       // second external clock drive
  localparam int OSC_N = 7;                      // raw vector: dco,hf,pll,wdt,ipo,low_freq_crystal_osc,ext2
  localparam int WDT_NOM_HZ = 10000;             // watchdog osc nominal rate
  localparam int PCLK_NOM_HZ = 32768;            // peripheral clock nominal rate

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_DRAIN = 2'b01,
    SW_ARM = 2'b11,
    SW_OPEN = 2'b10
  } sclksw_sw_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sclksw_req_s;

  typedef struct packed {
    logic [OSC_N-1:0] sync1;
    logic [OSC_N-1:0] sync2;
    logic [OSC_N-1:0] sync3;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic stage;
    logic [2:0] cur;
    logic on;
    sclksw_sw_e sw;
    logic mux;
    logic [HCNT_W-1:0] hcnt;
    logic [DIV_W-1:0] div_act;
    logic sclk;
    logic [1:0] pcur;
    logic pon;
    logic pclk;
    logic [7:0] rdata;
  } sclksw_state_s;

  localparam sclksw_state_s STATE_RST = '{
    sync1: '0, sync2: '0, sync3: '0, ctl0: CTL0_RST, ctl1: CTL1_RST, stage: 1'b0,
    cur: SRC_PCLK, on: 1'b1, sw: SW_IDLE, mux: 1'b0, hcnt: '0, div_act: '0,
    sclk: 1'b0, pcur: PCLK_IPO, pon: 1'b1, pclk: 1'b0, rdata: '0};

endpackage

// ---- testbench/sclksw_bench.sv ----
// self-checking bench for the system clock source switch
`timescale 1ns/1ps
module sclksw_bench
  import sclksw_pkg::*;
;
  // ----------------------------------------
  // stimulus and observation
  // ----------------------------------------
  localparam int HP[OSC_N] = '{5, 6, 7, 9, 10, 11, 8}; // osc half periods, clk cycles
  localparam int CEIL = 20000; // hang limit, about four times the sequence
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  sclksw_req_s req = '0;
  logic [OSC_N-1:0] osc_raw = '0;
  logic [OSC_N-1:0] osc_en = '1; // oscillators that software keeps running
  logic stop_mode = 1'b0;
  logic fast_recovery_enable = 1'b0;
  logic [7:0] rdata;
  logic sys_clk;
  logic pclk;
  logic [7:0] rd_v;
  logic [3:0] stp[4] = '{4'b0010, 4'b1000, 4'b1011, 4'b1101}; // keep,psel,fre,runs
  int oc[OSC_N];
  int run[2];
  int last[2];
  int minr[2] = '{1000, 1000};
  bit prv[2];
  bit seen[2];
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;

  sclksw_top u_sclksw_top (.clk(clk), .arst_n(arst_n), .req(req), .osc_raw(osc_raw),
    .stop_mode(stop_mode), .fast_recovery_enable(fast_recovery_enable), .rdata(rdata),
    .sys_clk(sys_clk), .pclk(pclk));

  // free running clock
  initial forever #20 clk = ~clk;

  // oscillators, level run monitor of both outputs, hang guard
  always @(posedge clk) begin
    for (int i = 0; i < OSC_N; i++) begin
      if (oc[i] >= HP[i] - 1) begin
        oc[i] <= 0;
        if (osc_en[i]) osc_raw[i] <= ~osc_raw[i];
      end else begin
        oc[i] <= oc[i] + 1;
      end
    end
    // a run is only complete between two toggles, so the first is skipped
    // levels under reset are unknown, so runs are timed only once it is released
    for (int k = 0; k < 2 && arst_n; k++) begin
      if ((k ? pclk : sys_clk) !== prv[k]) begin
        if (seen[k]) begin
          last[k] = run[k] + 1;
          if (last[k] < minr[k]) minr[k] = last[k];
        end
        seen[k] = 1'b1;
        prv[k] = ~prv[k];
        run[k] = 0;
      end else begin
        run[k] = run[k] + 1;
      end
    end
    cyc++;
    if (cyc == CEIL) begin
      miscompares++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // strobe for one cycle, then a quiet cycle so no signal is set twice in a step
  task automatic wr(logic [1:0] a, logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask

  task automatic rd(logic [1:0] a, output logic [7:0] d);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  task automatic rchk(string what, logic [1:0] a, logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(what, {8'h00, exp}, {8'h00, v});
  endtask

  // long enough for drain, arm and two full runs at the slowest ratio
  task automatic settle();
    repeat (300) @(posedge clk);
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rchk("ctl0", CTL0_ADDR, CTL0_RST);
    rchk("ctl1", CTL1_ADDR, CTL1_RST);
    rchk("unmapped", 2'h3, 8'h00);
    wr(CTL1_ADDR, 8'h05);
    rchk("ctl1", CTL1_ADDR, CTL1_RST);
    // wrong order, then a broken pair
    wr(CTL0_ADDR, UNLOCK_2);
    wr(CTL0_ADDR, UNLOCK_1);
    wr(CTL0_ADDR, 8'h55);
    wr(CTL0_ADDR, UNLOCK_2);
    rchk("ctl0", CTL0_ADDR, CTL0_RST);
    // good pair with other accesses between the steps
    wr(CTL0_ADDR, UNLOCK_1);
    wr(CTL1_ADDR, 8'h05);
    rchk("ctl1", CTL1_ADDR, CTL1_RST);
    wr(CTL0_ADDR, UNLOCK_2);
    rchk("ctl0", CTL0_ADDR, 8'h80);
    // every system source at two divider settings
    for (int dv = 0; dv < 4; dv += 2) begin
      wr(CTL1_ADDR, 8'(dv));
      for (int s = 0; s <= 4; s++) begin
        // every source, the pll reference too, runs from the start
        wr(CTL0_ADDR, 8'h80 | 8'(s));
        settle();
        rd(STAT_ADDR, rd_v);
        chk("sys_src", 16'(s), 16'(rd_v[2:0]));
        chk("pending", 16'h0000, 16'(rd_v[5]));
        chk("sys_half", 16'((s == 0 ? HP[4] : HP[s - 1]) << dv), 16'(last[0]));
      end
    end
    // system clock now on the watchdog osc: stop the dco, hf and pll oscillators it left
    osc_en[3:0] <= 4'b1000;
    // every peripheral clock source; no peripheral user or frequency locking runs here
    for (int p = 0; p < 3; p++) begin
      wr(CTL1_ADDR, 8'(p << PSEL_LSB));
      settle();
      rd(STAT_ADDR, rd_v);
      chk("pclk_src", 16'(p), 16'(rd_v[4:3]));
      chk("pclk_half", 16'(HP[4 + p]), 16'(last[1]));
    end
    chk("sys_half", 16'(HP[3]), 16'(last[0]));
    // stop mode keep and fast recovery combinations
    stop_mode <= 1'b1;
    foreach (stp[i]) begin
      fast_recovery_enable <= stp[i][1];
      wr(CTL1_ADDR, 8'({stp[i][3], 1'b0, stp[i][2]} << PSEL_LSB));
      settle();
      chk("pclk_still", 16'(!stp[i][0]), 16'(run[1] >= 60));
    end
    stop_mode <= 1'b0;
    // unlock values while unlocked simply load; the second one relocks
    wr(CTL0_ADDR, UNLOCK_1);
    rchk("ctl0", CTL0_ADDR, UNLOCK_1);
    // select code 7 names no source, so the switch stays put
    rd(STAT_ADDR, rd_v);
    chk("sys_src", 16'(SRC_WDT), 16'(rd_v[2:0]));
    chk("pending", 16'h0000, 16'(rd_v[5]));
    wr(CTL0_ADDR, UNLOCK_2);
    rchk("ctl0", CTL0_ADDR, UNLOCK_2);
    wr(CTL1_ADDR, 8'h07);
    rchk("ctl1", CTL1_ADDR, 8'h28);
    // no level ever shorter than the fastest source half period
    chk("sys_min", 16'h0001, 16'(minr[0] >= 5));
    chk("pclk_min", 16'h0001, 16'(minr[1] >= 5));
    end_of_test();
  end
endmodule
